//--- hdl/fbs_boot_timer.sv
// fbs_boot_timer: counts milliseconds after reset and raises ready once the
// programmed boot delay has elapsed. assumes delay_ms_i comes from the same clock.
`timescale 1ns/1ps
`include "fbs_defs.svh"
module fbs_boot_timer #(
	parameter int CYCLES_PER_MS = `FBS_MS_NS / `FBS_CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] delay_ms_i,
	output logic ready_o
);
	import fbs_pkg::*;

	localparam logic [17:0] TICK_LAST = 18'(CYCLES_PER_MS - 1);

	fbs_boot_state_t state_reg;
	fbs_boot_state_t state_next;
	logic [17:0] div_reg;
	logic [31:0] ms_reg;
	wire ms_tick = (div_reg == TICK_LAST);
	wire elapsed = (ms_reg >= delay_ms_i);

	always_comb begin
		case (state_reg)
			BOOT_START: state_next = BOOT_COUNT;
			BOOT_COUNT: state_next = elapsed ? BOOT_READY : BOOT_COUNT;
			BOOT_READY: state_next = BOOT_READY;
			default: state_next = BOOT_START;
		endcase
	end

	// ready is sticky; a later rewrite of the delay cannot take it back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= BOOT_START;
			div_reg <= 18'h00000;
			ms_reg <= 32'h00000000;
			ready_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			div_reg <= ms_tick ? 18'h00000 : div_reg + 18'h00001;
			if (ms_tick && ms_reg != 32'hffffffff) begin
				ms_reg <= ms_reg + 32'h00000001;
			end
			ready_o <= (state_next == BOOT_READY);
		end
	end
endmodule : fbs_boot_timer

//--- hdl/fbs_top.sv
// fbs_top: fieldbus select and boot configuration bank with its step input
// front end, reached over classic wishbone.
// assumes one 200 MHz clock and a synchronous active-high reset; step pins
// are asynchronous and are synchronised here.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fbs_defs.svh"
module fbs_top #(
	parameter int CYCLES_PER_MS = `FBS_MS_NS / `FBS_CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic step_a_i,
	input wire logic step_b_i,
	output logic step_pulse_o,
	output logic step_dir_o,
	output logic ccw_mode_o,
	output logic ready_o,
	output fbs_pkg::fbs_word_t fieldbus_enabled_o
);
	import fbs_pkg::*;

	// ********************************************************************
	// helper functions
	// ********************************************************************

	// merge write data into a register byte lane by byte lane
	function automatic fbs_word_t merge_lanes(input fbs_word_t old_val,
		input fbs_word_t new_val, input logic [3:0] sel);
		fbs_word_t res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_val[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_lanes

	// state of one fieldbus: fitted, and either fixed on or software-chosen
	function automatic logic fb_state(input logic fitted, input logic switchable,
		input logic requested);
		return fitted & (switchable ? requested : 1'b1);
	endfunction : fb_state

	// ********************************************************************
	// bus slave
	// ********************************************************************

	fbs_reg_if regs ();

	fbs_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.regs(regs)
	);

	// ********************************************************************
	// address decode
	// ********************************************************************

	wire hit_step = (regs.index == `FBS_IDX_STEP_MODE);
	wire hit_boot = (regs.index == `FBS_IDX_BOOT_DELAY);
	wire hit_avail = (regs.index == `FBS_IDX_AVAIL);
	wire hit_ctrl = (regs.index == `FBS_IDX_CTRL);
	wire hit_count = (regs.index == `FBS_IDX_STAT_COUNT);
	wire hit_mask = (regs.index == `FBS_IDX_STAT_MASK);
	wire hit_enabled = (regs.index == `FBS_IDX_STAT_ENABLED);
	wire wr_req = regs.req & regs.we;

	// ********************************************************************
	// writable registers
	// ********************************************************************

	fbs_word_t step_mode_reg;
	fbs_word_t step_mode_next;
	fbs_word_t boot_delay_reg;
	fbs_word_t boot_delay_next;
	fbs_word_t ctrl_reg;
	fbs_word_t ctrl_next;
	fbs_word_t enabled_reg;
	fbs_word_t enabled_next;

	assign step_mode_next = (wr_req & hit_step) ?
		merge_lanes(step_mode_reg, regs.wdat, regs.sel) : step_mode_reg;
	assign boot_delay_next = (wr_req & hit_boot) ?
		merge_lanes(boot_delay_reg, regs.wdat, regs.sel) : boot_delay_reg;
	assign ctrl_next = (wr_req & hit_ctrl) ?
		merge_lanes(ctrl_reg, regs.wdat, regs.sel) : ctrl_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_mode_reg <= `FBS_RST_STEP_MODE;
			boot_delay_reg <= `FBS_RST_BOOT_DELAY;
			ctrl_reg <= `FBS_RST_CTRL;
		end else begin
			step_mode_reg <= step_mode_next;
			boot_delay_reg <= boot_delay_next;
			ctrl_reg <= ctrl_next;
		end
	end

	// ********************************************************************
	// fieldbus selection
	// ********************************************************************

	localparam fbs_word_t AVAIL = `FBS_AVAIL_PRESET;
	// switchable mask is a fixed build constant
	localparam fbs_word_t SWITCH_MASK = `FBS_SWITCH_MASK;

	// a fieldbus that is not fitted never reads active, whatever was written
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_fb
			assign enabled_next[gi] = fb_state(AVAIL[gi], SWITCH_MASK[gi], ctrl_next[gi]);
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enabled_reg <= `FBS_RST_ENABLED;
			fieldbus_enabled_o <= `FBS_RST_ENABLED;
		end else begin
			enabled_reg <= enabled_next;
			fieldbus_enabled_o <= enabled_next;
		end
	end

	// ********************************************************************
	// read multiplexer
	// ********************************************************************

	// unmapped indices read zero and ignore writes; the bus still acks
	wire fbs_word_t rd_step = hit_step ? step_mode_reg : 32'h00000000;
	wire fbs_word_t rd_boot = hit_boot ? boot_delay_reg : 32'h00000000;
	wire fbs_word_t rd_avail = hit_avail ? AVAIL : 32'h00000000;
	wire fbs_word_t rd_ctrl = hit_ctrl ? ctrl_reg : 32'h00000000;
	wire fbs_word_t rd_count = hit_count ? {24'h000000, `FBS_STAT_COUNT} : 32'h00000000;
	wire fbs_word_t rd_mask = hit_mask ? SWITCH_MASK : 32'h00000000;
	wire fbs_word_t rd_enabled = hit_enabled ? enabled_reg : 32'h00000000;

	assign regs.rdat = rd_step | rd_boot | rd_avail | rd_ctrl | rd_count | rd_mask |
		rd_enabled;

	// ********************************************************************
	// boot readiness
	// ********************************************************************

	logic boot_ready;

	fbs_boot_timer #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_boot (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.delay_ms_i(boot_delay_reg),
		.ready_o(boot_ready)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
		end else begin
			ready_o <= boot_ready;
		end
	end

	// ********************************************************************
	// step input front end
	// ********************************************************************

	logic [1:0] pin_meta_reg;
	logic [1:0] pin_sync_reg;
	logic [1:0] pin_prev_reg;

	// first stage feeds the second stage only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_reg <= 2'h0;
			pin_sync_reg <= 2'h0;
			pin_prev_reg <= 2'h0;
		end else begin
			pin_meta_reg <= {step_b_i, step_a_i};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	wire ccw_mode = step_mode_reg[0];
	wire rise_a = pin_sync_reg[0] & ~pin_prev_reg[0];
	wire rise_b = pin_sync_reg[1] & ~pin_prev_reg[1];

	// step/direction: a steps, b gives direction
	wire sd_step = rise_a;
	wire sd_dir = pin_sync_reg[1];
	// cw/ccw: a steps forward, b backward; a tie cancels
	wire cw_step = rise_a ^ rise_b;
	wire cw_dir = rise_a;

	// no steps leave the block before it is ready
	wire step_next = boot_ready & (ccw_mode ? cw_step : sd_step);
	wire dir_next = ccw_mode ? (cw_step ? cw_dir : step_dir_o) : sd_dir;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_pulse_o <= 1'b0;
			step_dir_o <= 1'b0;
			ccw_mode_o <= 1'b0;
		end else begin
			step_pulse_o <= step_next;
			step_dir_o <= dir_next;
			ccw_mode_o <= ccw_mode;
		end
	end

endmodule : fbs_top

//--- hdl/fbs_wb_slave.sv
// fbs_wb_slave: classic wishbone slave, one wait state, registered ack and data.
// assumes the master holds its request until it sees ack.
`timescale 1ns/1ps
module fbs_wb_slave (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	fbs_reg_if.bus regs
);
	import fbs_pkg::*;

	fbs_bus_state_t state_reg;
	fbs_bus_state_t state_next;
	wire take_req = wb_cyc_i & wb_stb_i & (state_reg == BUS_IDLE);

	// the request pulse goes out on the same edge that will register the answer
	assign regs.req = take_req;
	assign regs.we = wb_we_i;
	assign regs.index = wb_adr_i[15:2];
	assign regs.wdat = wb_dat_i;
	assign regs.sel = wb_sel_i;

	always_comb begin
		case (state_reg)
			BUS_IDLE: state_next = take_req ? BUS_ACK : BUS_IDLE;
			BUS_ACK: state_next = BUS_IDLE;
			default: state_next = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			wb_ack_o <= take_req;
			wb_dat_o <= (take_req & ~wb_we_i) ? regs.rdat : 32'h00000000;
		end
	end
endmodule : fbs_wb_slave

//--- shared/fbs_defs.svh
// fbs_defs.svh: register indices, field positions, presets and timing figures
// of the fieldbus select and boot configuration bank.
// assumes one 200 MHz clock; included by bare name, definitions only.
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

// ********************************************************************
// register indices (byte address = 4 * index)
// ********************************************************************
`define FBS_IDX_STEP_MODE 14'h205b
`define FBS_IDX_BOOT_DELAY 14'h2084
`define FBS_IDX_AVAIL 14'h2101
`define FBS_IDX_CTRL 14'h2102
`define FBS_IDX_STAT_COUNT 14'h2103
`define FBS_IDX_STAT_MASK 14'h2180
`define FBS_IDX_STAT_ENABLED 14'h2181

// ********************************************************************
// fieldbus bit positions
// ********************************************************************
`define FBS_BIT_USB 0
`define FBS_BIT_DIFF_SERIAL 1
`define FBS_BIT_SE_SERIAL 2
`define FBS_BIT_CAN 3
`define FBS_BIT_PLAIN_ETH 4
`define FBS_BIT_IND_ETH_BUS 5
`define FBS_BIT_SPI 6
`define FBS_BIT_SERIAL_REG_PROTO 16
`define FBS_BIT_TCP_REG_PROTO 17
`define FBS_BIT_IND_IP_PROTO 18

// ********************************************************************
// presets
// ********************************************************************
`define FBS_RST_STEP_MODE 32'h00000000
`define FBS_RST_BOOT_DELAY 32'h00000000
`define FBS_AVAIL_PRESET 32'h00190001
`define FBS_RST_CTRL 32'h00190001
`define FBS_STAT_COUNT 8'h02
`define FBS_SWITCH_MASK 32'h00000000
`define FBS_RST_ENABLED 32'h00190001

// ********************************************************************
// timing
// ********************************************************************
`define FBS_CLK_PERIOD_NS 5
`define FBS_MS_NS 1000000

`endif

//--- shared/fbs_pkg.sv
// fbs_pkg: types shared by the fieldbus select and boot configuration bank.
// assumes nothing beyond a SystemVerilog compiler.
package fbs_pkg;

	// bus slave handshake, gray along idle -> ack
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} fbs_bus_state_t;

	// boot readiness, gray along start -> count -> ready
	typedef enum logic [1:0] {
		BOOT_START = 2'b00,
		BOOT_COUNT = 2'b01,
		BOOT_READY = 2'b11
	} fbs_boot_state_t;

	typedef logic [13:0] fbs_index_t;
	typedef logic [31:0] fbs_word_t;

endpackage : fbs_pkg

//--- shared/fbs_reg_if.sv
// fbs_reg_if: one-cycle register access request from the bus slave to the bank.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fbs_reg_if;
	import fbs_pkg::*;
	logic req;
	logic we;
	fbs_index_t index;
	fbs_word_t wdat;
	logic [3:0] sel;
	fbs_word_t rdat;

	modport bus (output req, output we, output index, output wdat, output sel, input rdat);
	modport bank (input req, input we, input index, input wdat, input sel, output rdat);
endinterface : fbs_reg_if

//--- test/fbs_top_sva.sv
// fbs_top_sva: bus handshake and register checks on the bank's top ports.
// assumes it is bound into fbs_top; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`include "fbs_defs.svh"
module fbs_top_sva
	import fbs_pkg::*;
	#(parameter int CYCLES_PER_MS = 4)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic step_a_i,
	input wire logic step_b_i,
	input wire logic step_pulse_o,
	input wire logic step_dir_o,
	input wire logic ccw_mode_o,
	input wire logic ready_o,
	input wire fbs_pkg::fbs_word_t fieldbus_enabled_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic [13:0] idx_w;
	assign idx_w = wb_adr_i[15:2];

	// ****************************************
	// sequences
	// ****************************************
	sequence s_take;
		$rose(wb_cyc_i && wb_stb_i);
	endsequence
	sequence s_rd_at(logic [13:0] i);
		wb_ack_o && !wb_we_i && idx_w == i;
	endsequence

	// ****************************************
	// properties
	// ****************************************
	property p_ack_after_take;
		s_take |=> wb_ack_o;
	endproperty
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_no_spurious_ack;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	property p_dat_quiet;
		!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h00000000;
	endproperty
	property p_avail_read;
		s_rd_at(`FBS_IDX_AVAIL) |-> wb_dat_o == 32'h00190001;
	endproperty
	property p_count_read;
		s_rd_at(`FBS_IDX_STAT_COUNT) |-> wb_dat_o == 32'h00000002;
	endproperty
	property p_mask_read;
		s_rd_at(`FBS_IDX_STAT_MASK) |-> wb_dat_o == 32'h00000000;
	endproperty
	property p_enabled_fixed;
		fieldbus_enabled_o == 32'h00190001;
	endproperty
	property p_ready_sticky;
		ready_o |=> ready_o;
	endproperty
	property p_mode_follow;
		wb_ack_o && wb_we_i && idx_w == `FBS_IDX_STEP_MODE && wb_sel_i[0]
			|=> ccw_mode_o == $past(wb_dat_i[0]);
	endproperty

	a_ack_after_take: assert property (p_ack_after_take) else $error("ack missing");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_no_spurious_ack: assert property (p_no_spurious_ack) else $error("ack unasked");
	a_dat_quiet: assert property (p_dat_quiet) else $error("read data not quiet");
	a_avail_read: assert property (p_avail_read) else $error("availability wrong");
	a_count_read: assert property (p_count_read) else $error("status count wrong");
	a_mask_read: assert property (p_mask_read) else $error("mask wrong");
	a_enabled_fixed: assert property (p_enabled_fixed) else $error("enabled changed");
	a_ready_sticky: assert property (p_ready_sticky) else $error("ready dropped");
	a_mode_follow: assert property (p_mode_follow) else $error("mode not applied");
endmodule : fbs_top_sva

bind fbs_top fbs_top_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_fbs_top_sva (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .step_a_i(step_a_i), .step_b_i(step_b_i),
	.step_pulse_o(step_pulse_o), .step_dir_o(step_dir_o), .ccw_mode_o(ccw_mode_o),
	.ready_o(ready_o), .fieldbus_enabled_o(fieldbus_enabled_o));

//--- test/testbench.sv
// testbench: directed register and step checks of fbs_top over wishbone.
// assumes a 200 MHz clock and the default all-zero switchable mask.
`timescale 1ns/1ps
`include "fbs_defs.svh"
module testbench;
	import fbs_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sa = 0, sb = 0;
	logic [15:0] adr = 16'h0000;
	logic [31:0] dat = 32'h00000000, rdat;
	logic [3:0] sel = 4'h0;
	logic ack, pls, dir, ccw, rdy;
	fbs_word_t fben;
	int fails = 0, n_checks = 0, cyc_cnt = 0;

	fbs_top #(.CYCLES_PER_MS(4)) i_fbs_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(rdat), .step_a_i(sa), .step_b_i(sb),
		.step_pulse_o(pls), .step_dir_o(dir), .ccw_mode_o(ccw), .ready_o(rdy),
		.fieldbus_enabled_o(fben));

	always #2.5 clk_i = ~clk_i;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// hang guard: whole run is well under this
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask : chk

	task automatic wb(input logic w, input logic [13:0] i, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic rd(input string nm, input logic [13:0] i, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, i, 32'h0, 4'h0, q);
		chk(nm, exp, q);
	endtask : rd

	task automatic wr(input logic [13:0] i, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb(1'b1, i, d, s, q);
	endtask : wr

	// counts step pulses over eight cycles after the pins change
	task automatic pins(input logic a, input logic b, input int exp_n, input logic exp_d);
		int n;
		n = 0;
		@(posedge clk_i);
		sa <= a;
		sb <= b;
		repeat (8) begin
			@(posedge clk_i);
			n += (pls === 1'b1);
		end
		chk("step pulses", exp_n, n);
		chk("step dir", exp_d, dir);
	endtask : pins

	task automatic t_presets();
		rd("step mode", `FBS_IDX_STEP_MODE, 32'h00000000);
		rd("boot delay", `FBS_IDX_BOOT_DELAY, 32'h00000000);
		rd("availability", `FBS_IDX_AVAIL, 32'h00190001);
		rd("control", `FBS_IDX_CTRL, 32'h00190001);
		rd("count", `FBS_IDX_STAT_COUNT, 32'h00000002);
		rd("mask", `FBS_IDX_STAT_MASK, 32'h00000000);
		rd("enabled", `FBS_IDX_STAT_ENABLED, 32'h00190001);
		rd("unmapped", 14'h0001, 32'h00000000);
		chk("ready", 1, rdy);
		$display("test presets done");
	endtask : t_presets

	task automatic t_read_only();
		wr(`FBS_IDX_AVAIL, 32'hffffffff, 4'hf);
		wr(`FBS_IDX_STAT_COUNT, 32'hffffffff, 4'hf);
		wr(`FBS_IDX_STAT_MASK, 32'hffffffff, 4'hf);
		wr(`FBS_IDX_STAT_ENABLED, 32'h00000000, 4'hf);
		wr(14'h0001, 32'hffffffff, 4'hf);
		rd("availability", `FBS_IDX_AVAIL, 32'h00190001);
		rd("count", `FBS_IDX_STAT_COUNT, 32'h00000002);
		rd("mask", `FBS_IDX_STAT_MASK, 32'h00000000);
		rd("enabled", `FBS_IDX_STAT_ENABLED, 32'h00190001);
		rd("unmapped", 14'h0001, 32'h00000000);
		$display("test read_only done");
	endtask : t_read_only

	task automatic t_rw();
		wr(`FBS_IDX_BOOT_DELAY, 32'hffffffff, 4'h5);
		rd("boot delay", `FBS_IDX_BOOT_DELAY, 32'h00ff00ff);
		wr(`FBS_IDX_CTRL, 32'h00000000, 4'hf);
		rd("control", `FBS_IDX_CTRL, 32'h00000000);
		rd("enabled", `FBS_IDX_STAT_ENABLED, 32'h00190001);
		wr(`FBS_IDX_CTRL, 32'hffffffff, 4'hf);
		rd("control", `FBS_IDX_CTRL, 32'hffffffff);
		chk("enabled pins", 32'h00190001, fben);
		$display("test rw done");
	endtask : t_rw

	task automatic t_step();
		wr(`FBS_IDX_STEP_MODE, 32'h00000001, 4'hf);
		rd("step mode", `FBS_IDX_STEP_MODE, 32'h00000001);
		chk("ccw mode", 1, ccw);
		pins(1'b1, 1'b0, 1, 1'b1);
		pins(1'b0, 1'b1, 1, 1'b0);
		pins(1'b0, 1'b0, 0, 1'b0);
		wr(`FBS_IDX_STEP_MODE, 32'h00000000, 4'hf);
		// the mode output follows the register one edge after the ack
		@(posedge clk_i);
		chk("ccw mode", 0, ccw);
		pins(1'b0, 1'b1, 0, 1'b1);
		pins(1'b1, 1'b1, 1, 1'b1);
		$display("test step done");
	endtask : t_step

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_presets();
		t_read_only();
		t_rw();
		t_step();
		give_verdict();
	end
endmodule : testbench
